// >>> pkg/flash_host_pkg.sv
// Purpose: Shared constants for the pin-level flash programming port.
// Assumes: One 125 MHz clock; pin inputs are asynchronous.
// Notes:   Command codes are {port 3 bits 7:6, port 2 bits 7:6}.
package flash_host_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int ARM_HOLD_NS = 1000000;
    localparam int ARM_HOLD_CYCLES =
        (ARM_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BURST_TIMEOUT_NS = 20000;
    localparam int BURST_TIMEOUT_CYCLES = BURST_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int ARM_CNT_W = 17;
    localparam int TIMER_W = 12;

    localparam logic [3:0] CMD_READ_SIG     = 4'h0;
    localparam logic [3:0] CMD_CHIP_ERASE   = 4'h1;
    localparam logic [3:0] CMD_BLOCK_ERASE  = 4'hD;
    localparam logic [3:0] CMD_SECTOR_ERASE = 4'hB;
    localparam logic [3:0] CMD_BYTE_PROG    = 4'hE;
    localparam logic [3:0] CMD_BURST_PROG   = 4'h6;
    localparam logic [3:0] CMD_VERIFY       = 4'hC;

    localparam logic [2:0] OP_CHIP_ERASE   = 3'h0;
    localparam logic [2:0] OP_BLOCK_ERASE  = 3'h1;
    localparam logic [2:0] OP_SECTOR_ERASE = 3'h2;
    localparam logic [2:0] OP_BYTE_PROG    = 3'h3;
    localparam logic [2:0] OP_BURST_FIRST  = 3'h4;
    localparam logic [2:0] OP_BURST_NEXT   = 3'h5;
    localparam logic [2:0] OP_BURST_END    = 3'h6;

    localparam logic [3:0]  BLOCK1_TAG      = 4'hF;
    localparam logic [15:0] SIG_ADDR_MAKER  = 16'h0030;
    localparam logic [15:0] SIG_ADDR_DEVICE = 16'h0031;
    localparam int ROW0_LSB = 6;
    localparam int ROW1_LSB = 5;
    localparam int PIN_W = 36;
    localparam int REQ_W = 27;
    localparam logic [PIN_W-1:0] PIN_RESET = 36'h0_0000_0000;
endpackage

// >>> verilog/req_buffer.sv
// Purpose: Two-entry buffer between the command decoder and the flash unit.
// Assumes: Same clock on both sides.
// Notes:   All outputs come from flip-flops; in_ready falls when both full.
`timescale 1ns/1ps
`default_nettype none
module req_buffer #(
    parameter int WIDTH = 27
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic             tail_valid;
    logic [WIDTH-1:0] tail_data;
    logic             next_head_valid;
    logic [WIDTH-1:0] next_head_data;
    logic             next_tail_valid;
    logic [WIDTH-1:0] next_tail_data;
    logic             push;
    logic             pop;

    always_comb begin
        push = in_valid & ~tail_valid;
        pop = out_valid & out_ready;
        next_head_valid = out_valid;
        next_head_data = out_data;
        next_tail_valid = tail_valid;
        next_tail_data = tail_data;
        if (pop) begin
            if (tail_valid) begin
                next_head_data = tail_data;
                next_tail_valid = 1'b0;
            end else begin
                next_head_valid = push;
                next_head_data = in_data;
            end
        end else if (push) begin
            if (!out_valid) begin
                next_head_valid = 1'b1;
                next_head_data = in_data;
            end else begin
                next_tail_valid = 1'b1;
                next_tail_data = in_data;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
            tail_valid <= 1'b0;
            tail_data <= '0;
            in_ready <= 1'b1;
        end else begin
            out_valid <= next_head_valid;
            out_data <= next_head_data;
            tail_valid <= next_tail_valid;
            tail_data <= next_tail_data;
            in_ready <= ~next_tail_valid;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/flash_host_port.sv
// Purpose: Pin-level programming port: arming, command decode, busy
//          handshake, complement polling and row burst termination.
// Assumes: REF_CLK is the internal oscillator; the flash array behind
//          FLASH_* performs the timed erase and program work.
// Notes:   Pins pass a three-stage synchroniser before use.
`timescale 1ns/1ps
`default_nettype none
module flash_host_port
    import flash_host_pkg::*;
#(
    parameter int         ARM_CYCLES  = ARM_HOLD_CYCLES,
    parameter logic [7:0] MAKER_CODE  = 8'hA5,  // Arbitrary value.
    parameter logic [7:0] DEVICE_CODE = 8'h5A   // Arbitrary value.
) (
    input  wire logic       REF_CLK,
    input  wire logic       SYS_RST,
    input  wire logic       RESET_PIN,
    input  wire logic       CODE_FETCH_STROBE_N,
    input  wire logic       EXTERNAL_ACCESS_N,
    input  wire logic       LATCH_PROGRAM_STROBE_N,
    input  wire logic [7:0] P0_IN,
    input  wire logic [7:0] P1_IN,
    input  wire logic [7:0] P2_IN,
    input  wire logic [7:0] P3_IN,
    input  wire logic       LOCK_BLOCK0,
    input  wire logic       LOCK_BLOCK1,
    input  wire logic       FLASH_READY,
    input  wire logic       FLASH_DONE,
    input  wire logic [7:0] FLASH_RDATA,
    output logic [7:0]      P0_OUT,
    output logic            P0_OE_N,
    output logic            READY_BUSY_N,
    output logic            HOST_MODE,
    output logic            ARMED,
    output logic            FLASH_VALID,
    output logic [2:0]      FLASH_OP,
    output logic [15:0]     FLASH_ADDR,
    output logic [7:0]      FLASH_WDATA,
    output logic [15:0]     FLASH_RADDR
);
    typedef enum logic [1:0] {MODE_OFF, MODE_ARMING, MODE_ARMED} mode_t;

    logic [PIN_W-1:0]     pin_s1;
    logic [PIN_W-1:0]     pin_s2;
    logic [PIN_W-1:0]     pin_s3;
    logic [PIN_W-1:0]     pins;
    logic [PIN_W-1:0]     next_pins;
    logic                 prev_strobe_n;
    mode_t                mode;
    mode_t                next_mode;
    logic [ARM_CNT_W-1:0] arm_cnt;
    logic [ARM_CNT_W-1:0] next_arm_cnt;
    logic                 busy;
    logic                 next_busy;
    logic                 erasing;
    logic                 next_erasing;
    logic [7:0]           last;
    logic [7:0]           next_last;
    logic                 burst_open;
    logic                 next_burst_open;
    logic [15:0]          burst_addr;
    logic [15:0]          next_burst_addr;
    logic [TIMER_W-1:0]   timer;
    logic [TIMER_W-1:0]   next_timer;
    logic [7:0]           next_p0_out;
    logic                 next_p0_oe_n;
    logic                 push;
    logic [2:0]           push_op;
    logic                 buf_ready;
    logic                 host;
    logic                 strobe_n;
    logic                 strobe_fall;
    logic                 access_n;
    logic [3:0]           cmd;
    logic [15:0]          addr;
    logic [7:0]           data;
    logic                 in_block1;
    logic                 locked;
    logic                 same_row;

    assign host = pins[35] & ~pins[34];
    assign access_n = pins[33];
    assign strobe_n = pins[32];
    assign data = pins[31:24];
    assign addr = {pins[5:4], pins[13:8], pins[23:16]};
    assign cmd = {pins[7:6], pins[15:14]};
    assign strobe_fall = prev_strobe_n & ~strobe_n;
    assign in_block1 = addr[15:12] == BLOCK1_TAG;
    assign locked = in_block1 ? LOCK_BLOCK1 : LOCK_BLOCK0;
    // Rows are half sectors: 64 bytes in the primary, 32 in the secondary.
    assign same_row = in_block1
        ? (addr[15:ROW1_LSB] == burst_addr[15:ROW1_LSB])
        : (addr[15:ROW0_LSB] == burst_addr[15:ROW0_LSB]);

    // A bit takes a new value only once stages two and three agree.
    always_comb begin
        next_pins = (pin_s2 & pin_s3) | (pins & (pin_s2 ^ pin_s3));
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_s1 <= PIN_RESET;
            pin_s2 <= PIN_RESET;
            pin_s3 <= PIN_RESET;
            pins <= PIN_RESET;
            prev_strobe_n <= 1'b0;
        end else begin
            pin_s1 <= {RESET_PIN, CODE_FETCH_STROBE_N, EXTERNAL_ACCESS_N,
                       LATCH_PROGRAM_STROBE_N, P0_IN, P1_IN, P2_IN, P3_IN};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pins <= next_pins;
            prev_strobe_n <= strobe_n;
        end
    end

    always_comb begin
        next_mode = mode;
        next_arm_cnt = arm_cnt;
        next_erasing = erasing;
        next_last = last;
        next_burst_open = burst_open;
        next_burst_addr = burst_addr;
        next_timer = timer;
        push = 1'b0;
        push_op = OP_BYTE_PROG;
        unique case (mode)
            MODE_OFF: begin
                next_arm_cnt = '0;
                if (host) begin
                    next_mode = MODE_ARMING;
                end
            end
            MODE_ARMING: begin
                if (!host) begin
                    next_mode = MODE_OFF;
                end else if (cmd == CMD_READ_SIG && access_n) begin
                    if (arm_cnt == ARM_CNT_W'(ARM_CYCLES - 1)) begin
                        next_mode = MODE_ARMED;
                    end else begin
                        next_arm_cnt = arm_cnt + 1'b1;
                    end
                end else begin
                    next_arm_cnt = '0;
                end
            end
            MODE_ARMED: begin
                if (!host) begin
                    next_mode = MODE_OFF;
                end
            end
        endcase
        // Strobed commands count only once armed.
        if (mode == MODE_ARMED && strobe_fall
            && !busy && buf_ready) begin
            unique case (cmd)
                CMD_CHIP_ERASE: begin
                    push = 1'b1;
                    push_op = OP_CHIP_ERASE;
                end
                CMD_BLOCK_ERASE: begin
                    push = (!addr[15] && !LOCK_BLOCK0)
                        || (in_block1 && !LOCK_BLOCK1);
                    push_op = OP_BLOCK_ERASE;
                end
                CMD_SECTOR_ERASE: begin
                    push = !locked;
                    push_op = OP_SECTOR_ERASE;
                end
                CMD_BYTE_PROG: begin
                    push = !locked;
                    push_op = OP_BYTE_PROG;
                end
                CMD_BURST_PROG: begin
                    push = !locked;
                    push_op = (burst_open && same_row)
                        ? OP_BURST_NEXT : OP_BURST_FIRST;
                end
                default: begin
                    push = 1'b0;
                end
            endcase
            if (push) begin
                next_erasing = push_op <= OP_SECTOR_ERASE;
                next_last = next_erasing ? 8'h00 : data;
                // Any other accepted command closes a burst; a burst command in a new row opens a fresh one.
                next_burst_open = cmd == CMD_BURST_PROG;
                next_burst_addr = addr;
                next_timer = '0;
            end
        end else if (burst_open && !busy && buf_ready) begin
            if (timer == TIMER_W'(BURST_TIMEOUT_CYCLES - 1)) begin
                push = 1'b1;
                push_op = OP_BURST_END;
                next_burst_open = 1'b0;
            end else begin
                next_timer = timer + 1'b1;
            end
        end else if (busy) begin
            next_timer = '0;
        end
        if (push && push_op != OP_BURST_END) begin
            next_busy = 1'b1;
        end else if (FLASH_DONE) begin
            next_busy = 1'b0;
        end else begin
            next_busy = busy;
        end
    end

    // Readback follows the command pins without waiting for a strobe.
    always_comb begin
        next_p0_out = 8'h00;
        next_p0_oe_n = 1'b1;
        if (host && strobe_n && cmd == CMD_READ_SIG) begin
            next_p0_oe_n = 1'b0;
            if (addr == SIG_ADDR_MAKER) begin
                next_p0_out = MAKER_CODE;
            end else if (addr == SIG_ADDR_DEVICE) begin
                next_p0_out = DEVICE_CODE;
            end
        end else if (mode == MODE_ARMED && strobe_n
                     && cmd == CMD_VERIFY && !locked) begin
            next_p0_oe_n = 1'b0;
            if (busy) begin
                next_p0_out = {~last[7], 3'h0, ~last[3], 3'h0};
                if (erasing) begin
                    next_p0_out = 8'h00;
                end
            end else if (burst_open) begin
                next_p0_out = {last[7], 3'h0, ~last[3], 3'h0};
            end else begin
                next_p0_out = FLASH_RDATA;
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mode <= MODE_OFF;
            arm_cnt <= '0;
            busy <= 1'b0;
            erasing <= 1'b0;
            last <= 8'h00;
            burst_open <= 1'b0;
            burst_addr <= 16'h0000;
            timer <= '0;
            P0_OUT <= 8'h00;
            P0_OE_N <= 1'b1;
            READY_BUSY_N <= 1'b1;
            HOST_MODE <= 1'b0;
            ARMED <= 1'b0;
            FLASH_RADDR <= 16'h0000;
        end else begin
            mode <= next_mode;
            arm_cnt <= next_arm_cnt;
            busy <= next_busy;
            erasing <= next_erasing;
            last <= next_last;
            burst_open <= next_burst_open;
            burst_addr <= next_burst_addr;
            timer <= next_timer;
            P0_OUT <= next_p0_out;
            P0_OE_N <= next_p0_oe_n;
            READY_BUSY_N <= ~next_busy;
            HOST_MODE <= next_mode != MODE_OFF;
            ARMED <= next_mode == MODE_ARMED;
            FLASH_RADDR <= addr;
        end
    end

    req_buffer #(
        .WIDTH(REQ_W)
    ) u_req_buffer (
        .clk      (REF_CLK),
        .rst      (SYS_RST),
        .in_valid (push),
        .in_ready (buf_ready),
        .in_data  ({push_op, addr, data}),
        .out_valid(FLASH_VALID),
        .out_ready(FLASH_READY),
        .out_data ({FLASH_OP, FLASH_ADDR, FLASH_WDATA})
    );
endmodule
`default_nettype wire

// >>> tb/flash_port_chk.sv
// Purpose: Port-level checks for the flash programming port.
// Assumes: One clock domain; SYS_RST is active high.
// Notes:   Bound to every instance of the port module.
`timescale 1ns/1ps
`default_nettype none
module flash_port_chk
    import flash_host_pkg::*;
(
    input wire logic        REF_CLK,
    input wire logic        SYS_RST,
    input wire logic        FLASH_READY,
    input wire logic        FLASH_DONE,
    input wire logic [7:0]  P0_OUT,
    input wire logic        P0_OE_N,
    input wire logic        READY_BUSY_N,
    input wire logic        HOST_MODE,
    input wire logic        ARMED,
    input wire logic        FLASH_VALID,
    input wire logic [2:0]  FLASH_OP,
    input wire logic [15:0] FLASH_ADDR,
    input wire logic [7:0]  FLASH_WDATA
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    req_hold_a: assert property (
        FLASH_VALID && !FLASH_READY |=> FLASH_VALID &&
        $stable({FLASH_OP, FLASH_ADDR, FLASH_WDATA}))
        else $error("flash request changed before acceptance");
    ready_cause_a: assert property (
        $rose(READY_BUSY_N) |-> $past(FLASH_DONE))
        else $error("ready rose without a finished operation");
    busy_request_a: assert property (
        $fell(READY_BUSY_N) |-> FLASH_VALID)
        else $error("busy without a flash request");
    unarmed_quiet_a: assert property (
        !ARMED |-> !FLASH_VALID)
        else $error("flash request before arming");
    arm_mode_a: assert property (
        ARMED |-> HOST_MODE)
        else $error("armed outside host mode");
    drive_mode_a: assert property (
        !P0_OE_N |-> HOST_MODE)
        else $error("port 0 driven outside host mode");
    poll_bits_a: assert property (
        (!READY_BUSY_N && !P0_OE_N) [*3] |->
        (P0_OUT & 8'h77) == 8'h00)
        else $error("busy readback has stray bits");
    op_code_a: assert property (
        FLASH_VALID |-> FLASH_OP <= OP_BURST_END)
        else $error("unknown flash operation code");
    block_sel_a: assert property (
        FLASH_VALID && FLASH_OP == OP_BLOCK_ERASE |->
        !FLASH_ADDR[15] || FLASH_ADDR[15:12] == BLOCK1_TAG)
        else $error("block erase with invalid block address");
endmodule

bind flash_host_port flash_port_chk u_chk (
    .REF_CLK      (REF_CLK),
    .SYS_RST      (SYS_RST),
    .FLASH_READY  (FLASH_READY),
    .FLASH_DONE   (FLASH_DONE),
    .P0_OUT       (P0_OUT),
    .P0_OE_N      (P0_OE_N),
    .READY_BUSY_N (READY_BUSY_N),
    .HOST_MODE    (HOST_MODE),
    .ARMED        (ARMED),
    .FLASH_VALID  (FLASH_VALID),
    .FLASH_OP     (FLASH_OP),
    .FLASH_ADDR   (FLASH_ADDR),
    .FLASH_WDATA  (FLASH_WDATA)
);
`default_nettype wire

// >>> tb/flash_unit_model.sv
// Purpose: Behavioural flash array behind the programming port.
// Assumes: Requests arrive on the same clock as the port.
// Notes:   Stalls while busy; read data is a fixed function of address.
//          Each request waits one cycle before acceptance.
`timescale 1ns/1ps
`default_nettype none
module flash_unit_model
    import flash_host_pkg::*;
#(
    parameter int DONE_DLY = 60
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        valid,
    input  wire logic [2:0]  op,
    input  wire logic [15:0] raddr,
    output logic             ready,
    output logic             done,
    output logic      [7:0]  rdata
);
    int   cnt;
    logic waited;

    // A closing burst marker takes no array time and earns no done pulse.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt    <= 0;
            done   <= 1'b0;
            waited <= 1'b0;
        end else begin
            done <= (cnt == 1);
            // Holding a request off keeps the port's hold logic busy.
            waited <= valid & ~ready;
            if (cnt != 0) begin
                cnt <= cnt - 1;
            end else if (valid && ready && op != OP_BURST_END) begin
                cnt <= DONE_DLY;
            end
        end
    end
    assign ready = (cnt == 0) && waited;
    assign rdata = raddr[7:0] ^ 8'h3C;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the flash programming port.
// Assumes: The bench plays the host programmer; a model plays the array.
// Notes:   The arming hold is shortened through ARM_CYCLES.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import flash_host_pkg::*;
();
    localparam int ARM_N = 20;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rst_pin = 1'b1;
    logic        fetch_n = 1'b1;
    logic        access_n = 1'b0;
    logic        strobe_n = 1'b1;
    logic [7:0]  p0_in = 8'h00, p1_in = 8'h00, p2_in = 8'h00, p3_in = 8'h00;
    logic        lock0 = 1'b0, lock1 = 1'b0;
    logic        fl_ready, fl_done, p0_oe_n, rdy, host_mode, armed, fl_valid;
    logic [7:0]  fl_rdata, p0_out, fl_wdata;
    logic [2:0]  fl_op;
    logic [15:0] fl_addr, fl_raddr;
    logic [26:0] reqs[$];
    int          bad_count = 0;
    int          cmp_count = 0;

    always #4 clk = ~clk;
    always @(posedge clk) if (fl_valid && fl_ready)
        reqs.push_back({fl_op, fl_addr, fl_wdata});

    flash_host_port #(.ARM_CYCLES(ARM_N)) u_dut (
        .REF_CLK(clk), .SYS_RST(rst), .RESET_PIN(rst_pin),
        .CODE_FETCH_STROBE_N(fetch_n), .EXTERNAL_ACCESS_N(access_n),
        .LATCH_PROGRAM_STROBE_N(strobe_n), .P0_IN(p0_in), .P1_IN(p1_in),
        .P2_IN(p2_in), .P3_IN(p3_in), .LOCK_BLOCK0(lock0),
        .LOCK_BLOCK1(lock1), .FLASH_READY(fl_ready), .FLASH_DONE(fl_done),
        .FLASH_RDATA(fl_rdata), .P0_OUT(p0_out), .P0_OE_N(p0_oe_n),
        .READY_BUSY_N(rdy), .HOST_MODE(host_mode), .ARMED(armed),
        .FLASH_VALID(fl_valid), .FLASH_OP(fl_op), .FLASH_ADDR(fl_addr),
        .FLASH_WDATA(fl_wdata), .FLASH_RADDR(fl_raddr));
    flash_unit_model u_flash (
        .clk(clk), .rst(rst), .valid(fl_valid), .op(fl_op),
        .raddr(fl_raddr), .ready(fl_ready), .done(fl_done),
        .rdata(fl_rdata));

    task check(input string what, input logic [23:0] s, input logic [23:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task pins(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d);
        p3_in = {c[3:2], a[15:14], 4'h0};
        p2_in = {c[1:0], a[13:8]};
        p1_in = a[7:0];
        p0_in = d;
    endtask
    task strobe;
        strobe_n = 1'b0;
        cyc(6);
        strobe_n = 1'b1;
    endtask
    task wait_rdy(input logic lvl);
        int n;
        n = 0;
        while (rdy !== lvl && n < 200) begin
            cyc(1);
            n++;
        end
        check("ready_busy", 24'(rdy), 24'(lvl));
    endtask
    task readback(input logic [15:0] a, input logic [7:0] e);
        pins(CMD_VERIFY, a, 8'h00);
        cyc(8);
        check("p0_oe_n", 24'(p0_oe_n), 24'h00_0000);
        check("p0_out", 24'(p0_out), 24'(e));
    endtask
    task run_ign(input logic [3:0] c, input logic [15:0] a);
        pins(c, a, 8'h5A);
        cyc(4);
        strobe();
        cyc(20);
        check("ignored_busy", 24'(rdy), 24'h00_0001);
        check("ignored_req", 24'(reqs.size()), 24'h00_0000);
    endtask
    task run_op(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d,
                input logic [2:0] op, input logic poll, input logic [7:0] pe);
        logic [26:0] r;
        r = '0;
        pins(c, a, d);
        cyc(4);
        strobe();
        wait_rdy(1'b0);
        if (poll) begin
            readback(a ^ 16'h0011, pe);
            pins(c, a, d);
        end
        wait_rdy(1'b1);
        check("req_count", 24'(reqs.size()), 24'h00_0001);
        if (reqs.size() != 0) r = reqs.pop_front();
        check("req_op", 24'(r[26:24]), 24'(op));
        if (op >= OP_BYTE_PROG) check("req_ad", r[23:0], {a, d});
    endtask

    task t_reset;
        check("reset_out", 24'({host_mode, armed, p0_oe_n, rdy, fl_valid}),
              24'h00_0006);
    endtask
    task t_arm;
        rst_pin = 1'b0;
        fetch_n = 1'b0;
        cyc(10);
        check("no_host", 24'(host_mode), 24'h00_0000);
        rst_pin = 1'b1;
        fetch_n = 1'b1;
        cyc(10);
        fetch_n = 1'b0;
        cyc(10);
        check("host_mode", 24'(host_mode), 24'h00_0001);
        access_n = 1'b1;
        run_ign(CMD_BYTE_PROG, 16'h0100);
        pins(CMD_READ_SIG, SIG_ADDR_MAKER, 8'h00);
        cyc(10);
        check("maker", 24'(p0_out), 24'h00_00A5);
        check("early_arm", 24'(armed), 24'h00_0000);
        pins(CMD_READ_SIG, SIG_ADDR_DEVICE, 8'h00);
        cyc(8);
        check("device", 24'(p0_out), 24'h00_005A);
        pins(CMD_READ_SIG, 16'h0040, 8'h00);
        cyc(8);
        check("sig_other", 24'(p0_out), 24'h00_0000);
        cyc(ARM_N);
        check("armed", 24'(armed), 24'h00_0001);
    endtask
    task t_prog;
        run_op(CMD_SECTOR_ERASE, 16'h0100, 8'h00, OP_SECTOR_ERASE, 1'b0,
               8'h00);
        run_op(CMD_BYTE_PROG, 16'h0100, 8'h17, OP_BYTE_PROG, 1'b1,
               8'h88);
        readback(16'h0100, 8'h3C);
    endtask
    task t_lock;
        lock1 = 1'b1;
        run_ign(CMD_BYTE_PROG, 16'hF010);
        run_ign(CMD_SECTOR_ERASE, 16'hF040);
        pins(CMD_VERIFY, 16'hF010, 8'h00);
        cyc(8);
        check("lock_read", 24'(p0_oe_n), 24'h00_0001);
        run_op(CMD_CHIP_ERASE, 16'hF000, 8'h00, OP_CHIP_ERASE, 1'b0,
               8'h00);
        lock1 = 1'b0;
    endtask
    task t_erase;
        run_op(CMD_BLOCK_ERASE, 16'h1000, 8'h00, OP_BLOCK_ERASE, 1'b1,
               8'h00);
        run_op(CMD_BLOCK_ERASE, 16'hF000, 8'h00, OP_BLOCK_ERASE, 1'b0,
               8'h00);
        run_ign(CMD_BLOCK_ERASE, 16'h9000);
        run_op(CMD_SECTOR_ERASE, 16'h0180, 8'h00, OP_SECTOR_ERASE, 1'b0,
               8'h00);
    endtask
    task t_burst;
        run_op(CMD_BURST_PROG, 16'h0040, 8'h17, OP_BURST_FIRST, 1'b1,
               8'h88);
        readback(16'h0040, 8'h08);
        run_op(CMD_BURST_PROG, 16'h0041, 8'h21, OP_BURST_NEXT, 1'b0,
               8'h00);
        cyc(2300);
        check("early_end", 24'(reqs.size()), 24'h00_0000);
        cyc(300);
        check("burst_end", 24'(reqs.size()), 24'h00_0001);
        if (reqs.size() != 0)
            check("end_op", 24'(reqs.pop_front() >> 24),
                  24'(OP_BURST_END));
        readback(16'h0041, 8'h7D);
        run_op(CMD_BURST_PROG, 16'h0042, 8'h33, OP_BURST_FIRST, 1'b0,
               8'h00);
        run_op(CMD_BURST_PROG, 16'h0080, 8'h44, OP_BURST_FIRST, 1'b0,
               8'h00);
    endtask

    initial begin
        cyc(4);
        rst = 1'b0;
        cyc(2);
        t_reset();
        t_arm();
        t_prog();
        t_lock();
        t_erase();
        t_burst();
        end_of_test();
    end
    initial begin
        #200000;
        bad_count++;
        $display("ERROR watchdog expected finish seen timeout");
        end_of_test();
    end
endmodule
`default_nettype wire
